// File: shared/ilk_pkg.sv
// Function
// [R01] Monitored-lock variant: actuator, lock, force enable outputs.
// [R02] Monitored-lock variant: unlocking drops both outputs.
// [R03] Actuator present: relock re-enables outputs.
// [R04] Force below threshold withholds output release.
// [R05] Actuator variant: actuator, force, lockability enable outputs; code gates on actuator and force only.
// [R06] Actuator variant: unlocking keeps outputs enabled.
// [R07] Violent separation: outputs off, LEDs alternate.
// [R08] Close guard, toggle control: LEDs blink together.
// [R09] Anti-tamper wait, LEDs off, toggle resumes.
// [R10] Latching force setting holds eight levels.
// [R11] Target held ten seconds at power-up enters adjustment.
// [R12] Adjustment mode keeps both outputs disabled.
// [R13] Target removed: yellow bursts show force level.
// [R14] Target one second, guard open: level up.
// [R15] Level eight wraps to level one.
// [R16] Power loss stores level, ends adjustment.
// [R17] Actuator variant, guard open: show level ten seconds.
// [R18] Monitoring module tolerates output self-test gaps.
// [R19] Control test pulses up to five ms ignored.
// [R20] All timeouts count clock-derived ticks, reset cleared.
package ilk_pkg;

  // Clock and tick base.
  localparam int unsigned CLK_FREQ_HZ = 32'h0EE6_B280;
  localparam int unsigned TICK_PERIOD_MS = 32'h0000_0001;
  localparam int unsigned TICK_CYCLES_DEF = CLK_FREQ_HZ / 32'h0000_03E8 * TICK_PERIOD_MS;
  localparam int PRESC_W = 18;

  // Durations in milliseconds and their tick counts.
  localparam int unsigned TEST_PULSE_MAX_MS = 32'h0000_0005;
  localparam int unsigned FILT_TICKS = TEST_PULSE_MAX_MS / TICK_PERIOD_MS + 32'h0000_0001;
  localparam int unsigned TAMPER_MS = 32'h0009_27C0;
  localparam int unsigned TAMPER_TICKS_DEF = TAMPER_MS / TICK_PERIOD_MS;
  localparam int unsigned ENTRY_MS = 32'h0000_2710;
  localparam int unsigned ENTRY_TICKS_DEF = ENTRY_MS / TICK_PERIOD_MS;
  localparam int unsigned SHOW_MS = 32'h0000_2710;
  localparam int unsigned SHOW_TICKS_DEF = SHOW_MS / TICK_PERIOD_MS;
  localparam int unsigned PRES_MS = 32'h0000_03E8;
  localparam int unsigned PRES_TICKS = PRES_MS / TICK_PERIOD_MS;
  localparam int unsigned SELFTEST_INT_MS = 32'h0000_03E8;
  localparam int unsigned SELFTEST_INT_TICKS = SELFTEST_INT_MS / TICK_PERIOD_MS;
  localparam int unsigned BLINK_MS = 32'h0000_00FA;
  localparam int unsigned BLINK_TICKS = BLINK_MS / TICK_PERIOD_MS;
  localparam int unsigned FLASH_ON_MS = 32'h0000_00C8;
  localparam int unsigned FLASH_OFF_MS = 32'h0000_00C8;
  localparam int unsigned FLASH_PAUSE_MS = 32'h0000_03E8;

  // Counter widths and force levels.
  localparam int TMR_W = 20;
  localparam int SHORT_W = 10;
  localparam int LEVEL_W = 3;
  localparam logic [LEVEL_W-1:0] LEVEL_RST = 3'h0;
  localparam int BOOT_W = 2;
  localparam logic [BOOT_W-1:0] BOOT_DONE = 2'h3;

  // Synchroniser bit positions.
  localparam int IN_W = 11;
  localparam int IN_ACT = 0;
  localparam int IN_LOCK = 1;
  localparam int IN_FORCE = 2;
  localparam int IN_TARGET = 3;
  localparam int IN_CTRL = 4;
  localparam int IN_VARAM = 5;
  localparam int IN_ADJOPT = 6;
  localparam int IN_PFAIL = 7;
  localparam int IN_LVL = 8;

  typedef enum logic [7:0] {
    ST_BOOT = 8'h01,
    ST_SEARCH = 8'h02,
    ST_ADJUST = 8'h04,
    ST_SHOWLVL = 8'h08,
    ST_RUN = 8'h10,
    ST_SEP_FAULT = 8'h20,
    ST_SEP_WAIT = 8'h40,
    ST_SEP_DONE = 8'h80
  } ilk_state_e;

  typedef enum logic [2:0] {
    FL_ON = 3'h1,
    FL_OFF = 3'h2,
    FL_PAUSE = 3'h4
  } ilk_flash_e;

  // True on the last count of a timer that runs to lim ticks.
  function automatic logic ilkCntHit(input logic [TMR_W-1:0] c, input int unsigned lim);
    return c == TMR_W'(lim - 32'h0000_0001);
  endfunction : ilkCntHit

endpackage : ilk_pkg

// File: shared/ilk_flash_if.sv
`timescale 1ns/100ps
interface ilk_flash_if;
  logic tick;
  logic enable;
  logic [2:0] level;
  logic lamp;
  modport ctrl (output tick, output enable, output level, input lamp);
  modport gen (input tick, input enable, input level, output lamp);
endinterface : ilk_flash_if

// File: core/ilk_flash_gen.sv
`timescale 1ns/100ps
module ilk_flash_gen
  import ilk_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Burst request and lamp
  ilk_flash_if.gen fl
);

  ilk_flash_e flSt_r;
  logic [SHORT_W-1:0] flCnt_r;
  logic [LEVEL_W-1:0] flIdx_r;
  logic lamp_r;

  // Bursts of level+1 short flashes, then a pause, repeated.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      flSt_r <= FL_ON;
      flCnt_r <= '0;
      flIdx_r <= '0;
    end else if (!fl.enable) begin
      flSt_r <= FL_ON;
      flCnt_r <= '0;
      flIdx_r <= '0;
    end else if (fl.tick) begin
      flCnt_r <= flCnt_r + 1'b1;
      case (flSt_r)
        FL_ON: begin
          if (flCnt_r == SHORT_W'(FLASH_ON_MS / TICK_PERIOD_MS - 1)) begin
            flSt_r <= FL_OFF;
            flCnt_r <= '0;
          end
        end
        FL_OFF: begin
          if (flCnt_r == SHORT_W'(FLASH_OFF_MS / TICK_PERIOD_MS - 1)) begin
            flCnt_r <= '0;
            if (flIdx_r == fl.level) begin // R13
              flSt_r <= FL_PAUSE;
              flIdx_r <= '0;
            end else begin
              flSt_r <= FL_ON;
              flIdx_r <= flIdx_r + 1'b1;
            end
          end
        end
        FL_PAUSE: begin
          if (flCnt_r == SHORT_W'(FLASH_PAUSE_MS / TICK_PERIOD_MS - 1)) begin
            flSt_r <= FL_ON;
            flCnt_r <= '0;
          end
        end
        default: begin
          flSt_r <= FL_ON;
          flCnt_r <= '0;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      lamp_r <= 1'b0;
    end else begin
      lamp_r <= fl.enable && (flSt_r == FL_ON);
    end
  end

  assign fl.lamp = lamp_r;

endmodule : ilk_flash_gen

// File: core/ilk_interlock_ctrl.sv
`timescale 1ns/100ps
module ilk_interlock_ctrl
  import ilk_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = TICK_CYCLES_DEF,
  parameter int unsigned TAMPER_TICKS = TAMPER_TICKS_DEF,
  parameter int unsigned ENTRY_TICKS = ENTRY_TICKS_DEF,
  parameter int unsigned SHOW_TICKS = SHOW_TICKS_DEF
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Sensors
  input wire logic actuatorDetect,
  input wire logic lockSense,
  input wire logic forceOk,
  input wire logic targetSense,
  // Control and supply
  input wire logic solenoidCtrl,
  input wire logic powerFail,
  // Straps and stored setting
  input wire logic variantActMon,
  input wire logic adjustableForceOption,
  input wire logic [LEVEL_W-1:0] storedLevel,
  // Safety outputs
  output logic safetyOutputChA,
  output logic safetyOutputChB,
  // Actuation, indication and storage
  output logic magnetDrive,
  output logic ledYellow,
  output logic ledRed,
  output logic [LEVEL_W-1:0] forceLevel,
  output logic nvStoreReq
);

  logic [IN_W-1:0] syncA_r;
  logic [IN_W-1:0] syncB_r;
  logic actS;
  logic lockS;
  logic forceS;
  logic targetS;
  logic [PRESC_W-1:0] presc_r;
  logic tick_r;
  logic ctrlFilt_r;
  logic [3:0] filtCnt_r;
  logic offSeen_r;
  logic toggleDone;
  ilk_state_e state_r;
  ilk_state_e state_nxt;
  logic stateChg;
  logic [BOOT_W-1:0] bootCnt_r;
  logic varAm_r;
  logic [TMR_W-1:0] tmr_r;
  logic [SHORT_W-1:0] presCnt_r;
  logic stepArm_r;
  logic levelStep;
  logic [LEVEL_W-1:0] level_r;
  logic pfPrev_r;
  logic nvStore_r;
  logic [SHORT_W-1:0] stCnt_r;
  logic testOff_r;
  logic lockedPrev_r;
  logic sepEvt;
  logic runEn;
  logic chA_r;
  logic chB_r;
  logic [SHORT_W-1:0] blinkCnt_r;
  logic blink_r;
  logic yellow_nxt;
  logic red_nxt;
  logic yellow_r;
  logic red_r;
  logic magnet_r;
  ilk_flash_if flIf ();

  // Two-stage synchroniser for every pin.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      syncA_r <= '0;
      syncB_r <= '0;
    end else begin
      syncA_r <= {storedLevel, powerFail, adjustableForceOption, variantActMon,
                  solenoidCtrl, targetSense, forceOk, lockSense, actuatorDetect};
      syncB_r <= syncA_r;
    end
  end

  assign actS = syncB_r[IN_ACT];
  assign lockS = syncB_r[IN_LOCK];
  assign forceS = syncB_r[IN_FORCE];
  assign targetS = syncB_r[IN_TARGET];

  // Time base tick from the system clock.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      presc_r <= '0;
      tick_r <= 1'b0;
    end else if (presc_r == PRESC_W'(TICK_CYCLES - 1)) begin // R20
      presc_r <= '0;
      tick_r <= 1'b1;
    end else begin
      presc_r <= presc_r + 1'b1;
      tick_r <= 1'b0;
    end
  end

  // Control input filter; short low or high pulses never pass.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ctrlFilt_r <= 1'b0;
      filtCnt_r <= '0;
    end else if (syncB_r[IN_CTRL] == ctrlFilt_r) begin
      filtCnt_r <= '0;
    end else if (tick_r) begin
      if (filtCnt_r == 4'(FILT_TICKS - 1)) begin // R19
        ctrlFilt_r <= syncB_r[IN_CTRL];
        filtCnt_r <= '0;
      end else begin
        filtCnt_r <= filtCnt_r + 1'b1;
      end
    end
  end

  // Off-then-on detection of the filtered control, rearmed per state.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      offSeen_r <= 1'b0;
    end else if (stateChg) begin
      offSeen_r <= 1'b0;
    end else if (!ctrlFilt_r) begin
      offSeen_r <= 1'b1;
    end
  end

  assign toggleDone = offSeen_r && ctrlFilt_r;
  assign stateChg = state_nxt != state_r;

  // Separation: actuator lost while it was held locked.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      lockedPrev_r <= 1'b0;
    end else begin
      lockedPrev_r <= actS && lockS;
    end
  end

  assign sepEvt = (state_r == ST_RUN) && !varAm_r && lockedPrev_r && !actS;

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_BOOT: begin
        if (bootCnt_r == BOOT_DONE) begin
          if (syncB_r[IN_ADJOPT] && targetS) begin
            state_nxt = ST_SEARCH;
          end else if (syncB_r[IN_VARAM] && !actS) begin
            state_nxt = ST_SHOWLVL; // R17
          end else begin
            state_nxt = ST_RUN; // R16
          end
        end
      end
      ST_SEARCH: begin
        if (!targetS) begin
          state_nxt = ST_RUN;
        end else if (tick_r && ilkCntHit(tmr_r, ENTRY_TICKS)) begin
          state_nxt = ST_ADJUST; // R11
        end
      end
      ST_ADJUST: begin
        state_nxt = ST_ADJUST;
      end
      ST_SHOWLVL: begin
        if (tick_r && ilkCntHit(tmr_r, SHOW_TICKS)) begin
          state_nxt = ST_RUN; // R17
        end
      end
      ST_RUN: begin
        if (sepEvt) begin
          state_nxt = ST_SEP_FAULT; // R07
        end
      end
      ST_SEP_FAULT: begin
        if (actS && toggleDone) begin
          state_nxt = ST_SEP_WAIT; // R08
        end
      end
      ST_SEP_WAIT: begin
        if (tick_r && actS && ilkCntHit(tmr_r, TAMPER_TICKS)) begin
          state_nxt = ST_SEP_DONE; // R09
        end
      end
      ST_SEP_DONE: begin
        if (toggleDone) begin
          state_nxt = ST_RUN; // R09
        end
      end
      default: begin
        state_nxt = ST_BOOT;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= ST_BOOT;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Boot delay lets the synchroniser fill before straps are caught.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      bootCnt_r <= '0;
      varAm_r <= 1'b0;
    end else if (state_r == ST_BOOT) begin
      if (bootCnt_r != BOOT_DONE) begin
        bootCnt_r <= bootCnt_r + 1'b1;
      end else begin
        varAm_r <= syncB_r[IN_VARAM];
      end
    end
  end

  // Shared state timer; the anti-tamper wait restarts when the guard opens.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      tmr_r <= '0;
    end else if (stateChg || (state_r == ST_SEP_WAIT && !actS)) begin // R09
      tmr_r <= '0;
    end else if (tick_r && tmr_r != '1) begin // R20
      tmr_r <= tmr_r + 1'b1;
    end
  end

  // Target presence in adjustment mode; one step per placement.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      presCnt_r <= '0;
      stepArm_r <= 1'b0;
    end else if (state_r != ST_ADJUST || stateChg) begin
      presCnt_r <= '0;
      stepArm_r <= 1'b0;
    end else if (!targetS) begin
      presCnt_r <= '0;
      stepArm_r <= 1'b1;
    end else if (levelStep) begin
      presCnt_r <= '0;
      stepArm_r <= 1'b0;
    end else if (tick_r && stepArm_r) begin
      presCnt_r <= presCnt_r + 1'b1;
    end
  end

  assign levelStep = (state_r == ST_ADJUST) && targetS && !actS && stepArm_r && tick_r
                     && presCnt_r == SHORT_W'(PRES_TICKS - 1); // R14

  // Force level: loaded from storage at boot, stepped with wrap.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      level_r <= LEVEL_RST;
    end else if (state_r == ST_BOOT && bootCnt_r == BOOT_DONE) begin
      level_r <= syncB_r[IN_LVL +: LEVEL_W]; // R10
    end else if (levelStep) begin
      level_r <= level_r + 1'b1; // R15
    end
  end

  // Store request on the rising edge of the power-fail warning.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pfPrev_r <= 1'b0;
      nvStore_r <= 1'b0;
    end else begin
      pfPrev_r <= syncB_r[IN_PFAIL];
      nvStore_r <= syncB_r[IN_PFAIL] && !pfPrev_r; // R16
    end
  end

  // Periodic output self-test: one tick off per interval.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      stCnt_r <= '0;
      testOff_r <= 1'b0;
    end else if (tick_r) begin
      if (stCnt_r == SHORT_W'(SELFTEST_INT_TICKS - 1)) begin
        stCnt_r <= '0;
        testOff_r <= 1'b1; // R18
      end else begin
        stCnt_r <= stCnt_r + 1'b1;
        testOff_r <= 1'b0;
      end
    end
  end

  // Enable conditions per variant; only the run state may release.
  always_comb begin
    runEn = 1'b0;
    if (state_r == ST_RUN) begin // R12
      if (varAm_r) begin
        runEn = actS && forceS; // R05 R06
      end else begin
        runEn = actS && lockS && forceS; // R01 R02 R03 R04
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      chA_r <= 1'b0;
      chB_r <= 1'b0;
    end else begin
      chA_r <= runEn && !sepEvt && !testOff_r; // R07
      chB_r <= runEn && !sepEvt && !testOff_r;
    end
  end

  // Slow blink for fault and approach indication.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      blinkCnt_r <= '0;
      blink_r <= 1'b0;
    end else if (tick_r) begin
      if (blinkCnt_r == SHORT_W'(BLINK_TICKS - 1)) begin
        blinkCnt_r <= '0;
        blink_r <= !blink_r;
      end else begin
        blinkCnt_r <= blinkCnt_r + 1'b1;
      end
    end
  end

  assign flIf.tick = tick_r;
  assign flIf.level = level_r;
  assign flIf.enable = (state_r == ST_ADJUST && !targetS) || state_r == ST_SHOWLVL; // R13 R17

  ilk_flash_gen uFlash (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .fl(flIf.gen)
  );

  always_comb begin
    yellow_nxt = 1'b0;
    red_nxt = 1'b0;
    case (state_r)
      ST_ADJUST, ST_SHOWLVL: begin
        yellow_nxt = flIf.lamp;
      end
      ST_RUN: begin
        yellow_nxt = (actS && lockS) || (actS && blink_r);
      end
      ST_SEP_FAULT: begin
        yellow_nxt = blink_r; // R07
        red_nxt = !blink_r;
      end
      ST_SEP_WAIT: begin
        yellow_nxt = blink_r; // R08
        red_nxt = blink_r;
      end
      default: begin
        yellow_nxt = 1'b0;
        red_nxt = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      yellow_r <= 1'b0;
      red_r <= 1'b0;
      magnet_r <= 1'b0;
    end else begin
      yellow_r <= yellow_nxt;
      red_r <= red_nxt;
      magnet_r <= ctrlFilt_r && state_r != ST_ADJUST && state_r != ST_BOOT;
    end
  end

  assign safetyOutputChA = chA_r;
  assign safetyOutputChB = chB_r;
  assign magnetDrive = magnet_r;
  assign ledYellow = yellow_r;
  assign ledRed = red_r;
  assign forceLevel = level_r;
  assign nvStoreReq = nvStore_r;

  a_lm_enable_cond: // R01
  assert property (@(posedge clk_sys) disable iff (!rst_n)
    (safetyOutputChA && !varAm_r) |-> $past(actS && lockS && forceS))
    else $error("Channel A enabled without actuator, lock and force.");

  a_lm_unlock_off: // R02
  assert property (@(posedge clk_sys) disable iff (!rst_n)
    (state_r == ST_RUN && !varAm_r && !lockS) |=> !safetyOutputChA && !safetyOutputChB)
    else $error("Outputs stayed on after unlock.");

  a_force_low_off: // R04
  assert property (@(posedge clk_sys) disable iff (!rst_n)
    !forceS |=> !safetyOutputChA)
    else $error("Output released with low latching force.");

  a_am_unlock_keep: // R06
  assert property (@(posedge clk_sys) disable iff (!rst_n)
    (state_r == ST_RUN && varAm_r && actS && forceS && !lockS && !testOff_r)
    |=> safetyOutputChA && safetyOutputChB)
    else $error("Actuator variant dropped outputs on unlock.");

  a_sep_react: // R07
  assert property (@(posedge clk_sys) disable iff (!rst_n)
    sepEvt |=> (state_r == ST_SEP_FAULT) && !safetyOutputChA ##1 !safetyOutputChA)
    else $error("Separation did not switch outputs off.");

  a_tamper_wait: // R09
  assert property (@(posedge clk_sys) disable iff (!rst_n)
    (state_r == ST_SEP_DONE && $past(state_r) == ST_SEP_WAIT)
    |-> $past(tmr_r) == TMR_W'(TAMPER_TICKS - 1) && $past(actS))
    else $error("Anti-tamper wait ended early.");

  a_adj_outs_off: // R12
  assert property (@(posedge clk_sys) disable iff (!rst_n)
    (state_r == ST_ADJUST && $past(state_r == ST_ADJUST)) |-> !safetyOutputChA && !safetyOutputChB)
    else $error("Output enabled in adjustment mode.");

  a_level_step: // R14
  assert property (@(posedge clk_sys) disable iff (!rst_n)
    (levelStep && level_r != 3'h7) |=> level_r == $past(level_r) + 3'h1)
    else $error("Force level did not advance by one.");

  a_level_wrap: // R15
  assert property (@(posedge clk_sys) disable iff (!rst_n)
    (levelStep && level_r == 3'h7) |=> level_r == 3'h0)
    else $error("Force level did not wrap to the first level.");

  a_store_pulse: // R16
  assert property (@(posedge clk_sys) disable iff (!rst_n)
    nvStoreReq |=> !nvStoreReq)
    else $error("Store request longer than one cycle.");

  a_ctrl_filter: // R19
  assert property (@(posedge clk_sys) disable iff (!rst_n)
    (ctrlFilt_r != $past(ctrlFilt_r)) |-> $past(filtCnt_r) == 4'(FILT_TICKS - 1))
    else $error("Control changed before the filter time.");

endmodule : ilk_interlock_ctrl

// File: verif/ilk_safety_monitor.sv
`timescale 1ns/100ps
module ilk_safety_monitor #(
  parameter int GAP_MAX = 8
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Safety channels
  input wire logic chanA,
  input wire logic chanB,
  // Findings
  output logic [7:0] gapCount,
  output logic [7:0] demandCount,
  output logic [7:0] pairCount
);
  logic [7:0] offLen_r;

  // Short switch-offs are tolerated as self-tests; longer ones count as a demand.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      offLen_r <= 8'h00;
      gapCount <= 8'h00;
      demandCount <= 8'h00;
    end else if (chanA && chanB) begin
      if (offLen_r != 8'h00 && offLen_r <= 8'(GAP_MAX)) begin
        gapCount <= gapCount + 8'h01;
      end
      offLen_r <= 8'h00;
    end else if (offLen_r != 8'hFF) begin
      offLen_r <= offLen_r + 8'h01;
      if (offLen_r == 8'(GAP_MAX)) begin
        demandCount <= demandCount + 8'h01;
      end
    end
  end

  // The two channels are read as a pair; any disagreement is counted.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pairCount <= 8'h00;
    end else if (chanA !== chanB && pairCount != 8'hFF) begin
      pairCount <= pairCount + 8'h01;
    end
  end
endmodule : ilk_safety_monitor

// File: verif/tb_interlock_output_and_force_adjust.sv
`timescale 1ns/100ps
module tb_interlock_output_and_force_adjust;
  import ilk_pkg::*;
  localparam int TC = 4;
  typedef struct packed {logic act; logic lock; logic frc; logic exp;} ilk_row_s;
  logic clk_sys, rst_n, act, lock, frc, tgt, ctrl, pfail, varAm, adjOpt;
  logic chA, chB, mag, ledY, ledR, nvReq;
  logic [LEVEL_W-1:0] lvl, fLvl;
  logic [7:0] gapCnt, dmdCnt, pairCnt, g0, d0;
  int fails, checks_done, n, k;
  ilk_row_s lockRows [7] = '{4'b1010, 4'b1111, 4'b1100, 4'b1111, 4'b1010, 4'b0010, 4'b0000};
  ilk_row_s actRows [4] = '{4'b1111, 4'b1011, 4'b1000, 4'b0010};

  ilk_interlock_ctrl #(.TICK_CYCLES(TC), .TAMPER_TICKS(20), .ENTRY_TICKS(10), .SHOW_TICKS(10))
  u_ilk_interlock_ctrl (.clk_sys(clk_sys), .rst_n(rst_n), .actuatorDetect(act),
    .lockSense(lock), .forceOk(frc), .targetSense(tgt), .solenoidCtrl(ctrl),
    .powerFail(pfail), .variantActMon(varAm), .adjustableForceOption(adjOpt),
    .storedLevel(lvl), .safetyOutputChA(chA), .safetyOutputChB(chB), .magnetDrive(mag),
    .ledYellow(ledY), .ledRed(ledR), .forceLevel(fLvl), .nvStoreReq(nvReq));

  ilk_safety_monitor #(.GAP_MAX(2 * TC)) u_ilk_safety_monitor (.clk_sys(clk_sys),
    .rst_n(rst_n), .chanA(chA), .chanB(chB), .gapCount(gapCnt), .demandCount(dmdCnt),
    .pairCount(pairCnt));

  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  task automatic cyc(input int c);
    repeat (c) @(posedge clk_sys);
    #1;
  endtask : cyc

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // An enabled pair may sit in a self-test gap, so it is looked at again two ticks later.
  task automatic chk_out(input logic exp);
    if (exp && (chA !== 1'b1 || chB !== 1'b1)) begin
      cyc(2 * TC);
    end
    chk("safetyOutputChA", 8'(exp), 8'(chA));
    chk("safetyOutputChB", 8'(exp), 8'(chB));
  endtask : chk_out

  task automatic boot(input logic va, input logic ao, input logic t);
    rst_n = 1'b0;
    varAm = va;
    adjOpt = ao;
    tgt = t;
    {act, lock, frc, ctrl, pfail} = 5'h00;
    cyc(3);
    chk_out(1'b0);
    chk("ledYellow", 8'h00, 8'(ledY));
    rst_n = 1'b1;
    cyc(8);
  endtask : boot

  task automatic filt(input logic v);
    ctrl = v;
    cyc(8 * TC);
  endtask : filt

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : report_and_stop

  initial begin
    #400000;
    fails++;
    report_and_stop();
  end

  initial begin
    fails = 0;
    checks_done = 0;
    lvl = 3'h6;
    boot(1'b0, 1'b0, 1'b0);
    filt(1'b1);
    chk("magnetDrive", 8'h01, 8'(mag));
    foreach (lockRows[i]) begin
      {act, lock, frc} = lockRows[i][3:1];
      cyc(6);
      chk_out(lockRows[i].exp);
    end
    {act, lock, frc} = 3'b111;
    cyc(6);
    g0 = gapCnt;
    d0 = dmdCnt;
    cyc(1100 * TC);
    chk("self-test gaps", 8'h01, 8'((gapCnt - g0) != 8'h00));
    chk("demands", d0, dmdCnt);
    act = 1'b0;
    cyc(6);
    chk_out(1'b0);
    chk("alternate leds", 8'h01, 8'(ledR ^ ledY));
    act = 1'b1;
    filt(1'b0);
    filt(1'b1);
    chk("joint leds", 8'h01, 8'(ledR == ledY));
    chk_out(1'b0);
    cyc(25 * TC);
    chk("ledYellow", 8'h00, 8'(ledY));
    chk("ledRed", 8'h00, 8'(ledR));
    ctrl = 1'b0;
    cyc(4 * TC);
    ctrl = 1'b1;
    cyc(8 * TC);
    chk_out(1'b0);
    filt(1'b0);
    filt(1'b1);
    chk_out(1'b1);
    boot(1'b1, 1'b0, 1'b0);
    chk("show level", 8'h01, 8'(ledY));
    cyc(12 * TC);
    chk("show level end", 8'h00, 8'(ledY));
    foreach (actRows[i]) begin
      {act, lock, frc} = actRows[i][3:1];
      cyc(6);
      chk_out(actRows[i].exp);
    end
    boot(1'b0, 1'b1, 1'b1);
    tgt = 1'b0;
    {act, lock, frc} = 3'b111;
    cyc(12 * TC);
    chk_out(1'b1);
    boot(1'b0, 1'b1, 1'b1);
    cyc(12 * TC);
    {act, lock, frc} = 3'b111;
    cyc(6);
    chk_out(1'b0);
    {act, lock, frc, tgt} = 4'h0;
    cyc(6);
    chk("forceLevel", 8'h06, 8'(fLvl));
    for (n = 0; n < 1500 * TC && ledY !== 1'b1; n++) begin
      cyc(1);
    end
    chk("yellow burst", 8'h01, 8'(ledY));
    if (ledY !== 1'b1) begin
      report_and_stop();
    end
    for (k = 0; k < 2; k++) begin
      tgt = 1'b1;
      cyc(1010 * TC);
      tgt = 1'b0;
      cyc(6);
      chk("forceLevel", (k == 0) ? 8'h07 : 8'h00, 8'(fLvl));
    end
    pfail = 1'b1;
    for (n = 0; n < 8 && nvReq !== 1'b1; n++) begin
      cyc(1);
    end
    chk("nvStoreReq", 8'h01, 8'(nvReq));
    if (nvReq !== 1'b1) begin
      report_and_stop();
    end
    cyc(1);
    chk("nvStoreReq end", 8'h00, 8'(nvReq));
    chk("channel pairing", 8'h00, pairCnt);
    report_and_stop();
  end
endmodule : tb_interlock_output_and_force_adjust
